// File: gpp_cfg.svh
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

// Register offsets
`define GPP_OFS_INPUT_IRQ_FLAG        8'h13
`define GPP_OFS_ROW_PULL_SELECT_HI    8'h1a
`define GPP_OFS_COL_PULL_SELECT_LO    8'h1b
`define GPP_OFS_COL_PULL_SELECT_MID   8'h1c
`define GPP_OFS_COL_PULL_SELECT_HI    8'h1d
`define GPP_OFS_INPUT_IRQ_POLARITY_LO 8'h1e

// Reset values
`define GPP_RST_ROW_PULL_SELECT_HI    8'h00
`define GPP_RST_COL_PULL_SELECT_LO    8'h00
`define GPP_RST_COL_PULL_SELECT_MID   8'h00
`define GPP_RST_COL_PULL_SELECT_HI    8'h00
`define GPP_RST_INPUT_IRQ_POLARITY_LO 8'h00
`define GPP_RST_INPUT_IRQ_FLAG        8'h00

// Pull-select codes
`define GPP_PULL_UP_WEAK              2'h0
`define GPP_PULL_DOWN                 2'h1
`define GPP_PULL_UP_STRONG            2'h2
`define GPP_PULL_NONE                 2'h3

// Field layout
`define GPP_FIELD_W                   2
`define GPP_FIELDS_PER_REG            4
`define GPP_COL_HI_FIELDS             3
`define GPP_COL_HI_USED_MASK          8'h3f

`endif

// File: gpp_pin_model.sv
`timescale 1ns/1ns
module gpp_pin_model #(
   parameter int SETTLE_NS = 7
) (
   input  wire logic [7:0] level,
   output wire logic [7:0] pin
);
   // Contacts settle off the clock edge, so the sampling flops see a real async change
   assign #(SETTLE_NS) pin = level;
endmodule

// File: gpp_pkg.sv
package gpp_pkg;

   typedef logic [1:0] gpp_pull_sel_t;

   // One bit per on-chip resistor of a pin
   typedef struct packed {
      logic weak_pull_up;
      logic pull_down;
      logic strong_pull_up;
   } gpp_pull_en_s;

   // One register access from the serial host interface
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gpp_reg_req_s;

endpackage

// File: gpp_top.sv
`timescale 1ns/1ns
`include "gpp_cfg.svh"

// Behaviour
// - Code 00: weak pull-up only
// - Code 01: pull-down only
// - Code 10: strong pull-up only
// - Code 11: all pulls off
// - Row register: rows 7..4, two bits each
// - Column low register: columns 3..0
// - Column middle register: columns 7..4
// - Column high register: columns 10..8, top reserved
// - Polarity register: inputs 8..1, bit each
// - Polarity 0: low level sets flag
// - Polarity 1: high level sets flag
// - Flag reads 1, cleared by read once its level has gone
// - Event-routed input never sets level flag
module gpp_top #(
   parameter int NUM_INPUTS = 8,
   parameter int NUM_ROWS   = 4,
   parameter int NUM_COLS   = 11
) (
   input  wire logic                                  clk,
   input  wire logic                                  sys_rst,
   input  wire gpp_pkg::gpp_reg_req_s                 reg_req,
   output logic [7:0]                                 reg_rdata,
   input  wire logic [NUM_INPUTS-1:0]                 input_pin,
   input  wire logic [NUM_INPUTS-1:0]                 input_event_en,
   output gpp_pkg::gpp_pull_en_s [NUM_ROWS-1:0]       row_pull_en,
   output gpp_pkg::gpp_pull_en_s [NUM_COLS-1:0]       col_pull_en,
   output logic                                       input_level_irq
);

   // Turns one select field into the three resistor enables
   // At most one resistor is enabled, so the two pull-ups never fight
   function automatic gpp_pkg::gpp_pull_en_s pull_decode(input gpp_pkg::gpp_pull_sel_t sel);
      gpp_pkg::gpp_pull_en_s en;
      en = '0;
      unique case (sel)
         `GPP_PULL_UP_WEAK:   en.weak_pull_up   = 1'b1;
         `GPP_PULL_DOWN:      en.pull_down      = 1'b1;
         `GPP_PULL_UP_STRONG: en.strong_pull_up = 1'b1;
         `GPP_PULL_NONE:      en                = '0;
      endcase
      return en;
   endfunction

   // Register file
   logic [7:0]                  row_pull_select_hi;
   logic [7:0]                  col_pull_select_lo;
   logic [7:0]                  col_pull_select_mid;
   logic [7:0]                  col_pull_select_hi;
   logic [7:0]                  input_irq_polarity_lo;
   // Level flags, one per general input; bit 0 is input 1
   logic [NUM_INPUTS-1:0]       input_irq_flag;
   logic [NUM_INPUTS-1:0]       next_input_irq_flag;

   // Input synchroniser
   logic [NUM_INPUTS-1:0]       pin_meta;
   logic [NUM_INPUTS-1:0]       pin_sync;

   // Address decode
   // The flag register has no write decode, so writes to it are dropped
   wire                         hit_row_hi   = reg_req.addr == `GPP_OFS_ROW_PULL_SELECT_HI;
   wire                         hit_col_lo   = reg_req.addr == `GPP_OFS_COL_PULL_SELECT_LO;
   wire                         hit_col_mid  = reg_req.addr == `GPP_OFS_COL_PULL_SELECT_MID;
   wire                         hit_col_hi   = reg_req.addr == `GPP_OFS_COL_PULL_SELECT_HI;
   wire                         hit_polarity = reg_req.addr == `GPP_OFS_INPUT_IRQ_POLARITY_LO;
   wire                         hit_flag     = reg_req.addr == `GPP_OFS_INPUT_IRQ_FLAG;

   wire                         wr_row_hi    = reg_req.wr & hit_row_hi;
   wire                         wr_col_lo    = reg_req.wr & hit_col_lo;
   wire                         wr_col_mid   = reg_req.wr & hit_col_mid;
   wire                         wr_col_hi    = reg_req.wr & hit_col_hi;
   wire                         wr_polarity  = reg_req.wr & hit_polarity;
   wire                         rd_flag      = reg_req.rd & hit_flag;

   // Pin level that asserts each input's flag
   wire [NUM_INPUTS-1:0]        level_active =
      ~(pin_sync ^ input_irq_polarity_lo[NUM_INPUTS-1:0]);

   // Inputs handed to the event queue do not raise the level flag
   wire [NUM_INPUTS-1:0]        flag_set     = level_active & ~input_event_en;

   // Set wins over the clear-on-read so no level is lost in the read cycle
   // A flag whose level has gone away stays set until the host reads it
   assign next_input_irq_flag = flag_set | (rd_flag ? '0 : input_irq_flag);

   // Read mux; unmapped offsets read zero
   // A read and a write in one cycle both act; the read returns the old byte
   logic [7:0]                  read_mux;
   always_comb begin
      read_mux = 8'h00;
      if (hit_row_hi) begin
         read_mux = row_pull_select_hi;
      end else if (hit_col_lo) begin
         read_mux = col_pull_select_lo;
      end else if (hit_col_mid) begin
         read_mux = col_pull_select_mid;
      end else if (hit_col_hi) begin
         read_mux = col_pull_select_hi & `GPP_COL_HI_USED_MASK;
      end else if (hit_polarity) begin
         read_mux = input_irq_polarity_lo;
      end else if (hit_flag) begin
         read_mux = 8'(input_irq_flag);
      end
   end

   // Pins come from outside the clock domain
   // Reset to the pulled-up idle level so no false low is flagged after reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_meta <= '1;
         pin_sync <= '1;
      end else begin
         pin_meta <= input_pin;
         pin_sync <= pin_meta;
      end
   end

   // One process per register, so a write strobe touches exactly one byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         row_pull_select_hi <= `GPP_RST_ROW_PULL_SELECT_HI;
      end else if (wr_row_hi) begin
         row_pull_select_hi <= reg_req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         col_pull_select_lo <= `GPP_RST_COL_PULL_SELECT_LO;
      end else if (wr_col_lo) begin
         col_pull_select_lo <= reg_req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         col_pull_select_mid <= `GPP_RST_COL_PULL_SELECT_MID;
      end else if (wr_col_mid) begin
         col_pull_select_mid <= reg_req.wdata;
      end
   end

   // Reserved top pair never stores a written one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         col_pull_select_hi <= `GPP_RST_COL_PULL_SELECT_HI;
      end else if (wr_col_hi) begin
         col_pull_select_hi <= reg_req.wdata & `GPP_COL_HI_USED_MASK;
      end
   end

   // A new polarity acts on the next edge; flags already set stay set
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         input_irq_polarity_lo <= `GPP_RST_INPUT_IRQ_POLARITY_LO;
      end else if (wr_polarity) begin
         input_irq_polarity_lo <= reg_req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         input_irq_flag <= NUM_INPUTS'(`GPP_RST_INPUT_IRQ_FLAG);
      end else begin
         input_irq_flag <= next_input_irq_flag;
      end
   end

   // Read data is held until the next read strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         reg_rdata <= read_mux;
      end
   end

   // Built from the next flag value so the request leaves one edge sooner
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         input_level_irq <= 1'b0;
      end else begin
         input_level_irq <= |next_input_irq_flag;
      end
   end

   // Pull enables are registered so the pad controls never glitch on a write
   logic [4*`GPP_FIELD_W-1:0]                 row_fields;
   logic [11*`GPP_FIELD_W-1:0]                col_fields;
   wire gpp_pkg::gpp_pull_en_s [NUM_ROWS-1:0] next_row_pull_en;
   wire gpp_pkg::gpp_pull_en_s [NUM_COLS-1:0] next_col_pull_en;

   assign row_fields = row_pull_select_hi;
   // Reserved pair of the column high register stays out of the field map
   assign col_fields = {col_pull_select_hi[5:0],
                        col_pull_select_mid,
                        col_pull_select_lo};

   // Index 0 of each output is the lowest pin of its register
   for (genvar r = 0; r < NUM_ROWS; r++) begin : g_row
      assign next_row_pull_en[r] = pull_decode(row_fields[r*`GPP_FIELD_W +: `GPP_FIELD_W]);
   end

   for (genvar c = 0; c < NUM_COLS; c++) begin : g_col
      assign next_col_pull_en[c] = pull_decode(col_fields[c*`GPP_FIELD_W +: `GPP_FIELD_W]);
   end

   // Reset leaves every pin on the weak pull-up so open keypad lines read high
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         row_pull_en <= {NUM_ROWS{pull_decode(`GPP_PULL_UP_WEAK)}};
         col_pull_en <= {NUM_COLS{pull_decode(`GPP_PULL_UP_WEAK)}};
      end else begin
         row_pull_en <= next_row_pull_en;
         col_pull_en <= next_col_pull_en;
      end
   end

endmodule

// File: gpp_top_assertions.sv
`timescale 1ns/1ns
module gpp_top_assertions #(
   parameter int NUM_INPUTS = 8,
   parameter int NUM_ROWS   = 4,
   parameter int NUM_COLS   = 11
) (
   input wire logic                                 clk,
   input wire logic                                 sys_rst,
   input wire gpp_pkg::gpp_reg_req_s                reg_req,
   input wire logic [7:0]                           reg_rdata,
   input wire logic [NUM_INPUTS-1:0]                input_pin,
   input wire logic [NUM_INPUTS-1:0]                input_event_en,
   input wire gpp_pkg::gpp_pull_en_s [NUM_ROWS-1:0] row_pull_en,
   input wire gpp_pkg::gpp_pull_en_s [NUM_COLS-1:0] col_pull_en,
   input wire logic                                 input_level_irq
);
   // Mirror of the registers at 0x1a..0x1e
   logic [7:0] sh [5];
   function automatic logic [11:0] dec4(input logic [7:0] v);
      for (int i = 0; i < 4; i++)
         dec4[i*3 +: 3] = {v[i*2 +: 2] == 2'h0, v[i*2 +: 2] == 2'h1, v[i*2 +: 2] == 2'h2};
   endfunction
   always_ff @(posedge clk)
      for (int i = 0; i < 5; i++)
         if (sys_rst)
            sh[i] <= 8'h00;
         else if (reg_req.wr && reg_req.addr == 8'(8'h1a + i))
            sh[i] <= reg_req.wdata;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_row_map: assert property (
      row_pull_en == dec4($past(sh[0])))
      else $error("row pulls wrong");
   chk_col_lo: assert property (
      col_pull_en[3:0] == dec4($past(sh[1])))
      else $error("col 3..0 pulls wrong");
   chk_col_mid: assert property (
      col_pull_en[7:4] == dec4($past(sh[2])))
      else $error("col 7..4 pulls wrong");
   chk_col_hi: assert property (
      col_pull_en[10:8] == 9'(dec4($past(sh[3]))))
      else $error("col 10..8 pulls wrong");
   chk_resv_zero: assert property (
      reg_req.rd && reg_req.addr == 8'h1d |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved bits not zero");
   chk_pol_read: assert property (
      reg_req.rd && reg_req.addr == 8'h1e |=> reg_rdata == $past(sh[4]))
      else $error("polarity readback wrong");
   chk_low_set: assert property (
      (!input_pin[0] && !sh[4][0] && !input_event_en[0]) [*4] |-> input_level_irq)
      else $error("low level not flagged");
   chk_high_set: assert property (
      (input_pin[7] && sh[4][7] && !input_event_en[7]) [*4] |-> input_level_irq)
      else $error("high level not flagged");
   chk_read_clears: assert property (
      reg_req.rd && reg_req.addr == 8'h13 && input_event_en == 8'hff |=> !input_level_irq)
      else $error("flag read did not clear");
endmodule
bind gpp_top gpp_top_assertions #(.NUM_INPUTS(NUM_INPUTS), .NUM_ROWS(NUM_ROWS),
   .NUM_COLS(NUM_COLS))
   u_chk (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .input_pin(input_pin), .input_event_en(input_event_en), .row_pull_en(row_pull_en),
   .col_pull_en(col_pull_en), .input_level_irq(input_level_irq));

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic                         clk;
   logic                         sys_rst;
   gpp_pkg::gpp_reg_req_s        reg_req;
   logic [7:0]                   reg_rdata;
   logic [7:0]                   level;
   logic [7:0]                   input_pin;
   logic [7:0]                   input_event_en;
   gpp_pkg::gpp_pull_en_s [3:0]  row_pull_en;
   gpp_pkg::gpp_pull_en_s [10:0] col_pull_en;
   logic                         input_level_irq;
   int                           bad_count = 0;
   int                           cmp_count = 0;
   gpp_top dut (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .input_pin(input_pin), .input_event_en(input_event_en), .row_pull_en(row_pull_en),
      .col_pull_en(col_pull_en), .input_level_irq(input_level_irq));
   gpp_pin_model sw (.level(level), .pin(input_pin));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [11:0] exp4(input logic [7:0] v);
      for (int i = 0; i < 4; i++)
         exp4[i*3 +: 3] = {v[i*2 +: 2] == 2'h0, v[i*2 +: 2] == 2'h1, v[i*2 +: 2] == 2'h2};
   endfunction
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_req <= {1'b1, 1'b0, a, d};
      @(posedge clk);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      reg_req <= '0;
      #1 d = reg_rdata;
   endtask
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      logic [7:0] q;
      #1;
      chk(row_pull_en, exp4(8'h00));
      chk(col_pull_en[3:0], exp4(8'h00));
      chk(input_level_irq, 1'b0);
      for (int i = 0; i < 5; i++) begin
         rd(8'(8'h1a + i), q);
         chk(q, 8'h00);
      end
      $display("reset test done");
   endtask
   task automatic t_pulls(input logic [7:0] d);
      logic [7:0] q;
      for (int i = 0; i < 5; i++)
         wr(8'(8'h1a + i), d);
      @(posedge clk);
      #1;
      chk(row_pull_en, exp4(d));
      chk(col_pull_en[3:0], exp4(d));
      chk(col_pull_en[7:4], exp4(d));
      chk(col_pull_en[10:8], exp4(d) & 12'h1ff);
      for (int i = 0; i < 5; i++) begin
         rd(8'(8'h1a + i), q);
         chk(q, (i == 3) ? d & 8'h3f : d);
      end
      $display("pull test %h done", d);
   endtask
   task automatic t_unmapped;
      logic [7:0] q;
      wr(8'h30, 8'h5a);
      rd(8'h30, q);
      chk(q, 8'h00);
      wr(8'h1d, 8'hc0);
      rd(8'h1d, q);
      chk(q, 8'h00);
      $display("unmapped test done");
   endtask
   task automatic t_level;
      logic [7:0] q;
      wr(8'h1e, 8'hf0);
      level <= 8'hf0;
      settle;
      chk(input_level_irq, 1'b1);
      rd(8'h13, q);
      chk(q, 8'hff);
      rd(8'h13, q);
      chk(q, 8'hff);
      @(posedge clk);
      level <= 8'h0f;
      settle;
      rd(8'h13, q);
      chk(q, 8'hff);
      rd(8'h13, q);
      chk(q, 8'h00);
      chk(input_level_irq, 1'b0);
      wr(8'h1e, 8'h0f);
      settle;
      rd(8'h13, q);
      chk(q, 8'hff);
      @(posedge clk);
      input_event_en <= 8'hff;
      settle;
      rd(8'h13, q);
      rd(8'h13, q);
      chk(q, 8'h00);
      chk(input_level_irq, 1'b0);
      $display("level test done");
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      complete_run;
   end
   initial begin
      sys_rst = 1'b1;
      reg_req = '0;
      level = 8'h00;
      input_event_en = 8'h00;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_pulls(8'h1b);
      t_pulls(8'he4);
      t_pulls(8'h4e);
      t_pulls(8'hb1);
      t_unmapped;
      t_level;
      complete_run;
   end
endmodule
